// file: verification/tcu8_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Crystal stand-in. It stays low between bursts, so any stray tick points at the design.
module tcu8_osc_model (
  input  wire logic [7:0] burst_len, // Pulses per burst.
  input  wire logic       burst_go,  // Burst start.
  output var  logic       osc_pin    // Oscillator level.
);
  integer i;
  initial osc_pin = 1'b0;
  always @(posedge burst_go) begin
    for (i = 0; i < burst_len; i = i + 1) begin
      #170 osc_pin = 1'b1;
      #170 osc_pin = 1'b0;
    end
  end
endmodule // tcu8_osc_model
`default_nettype wire

// file: verification/tcu8_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcu8_timer_asserts (
  input wire logic       core_clk,             // Clock.
  input wire logic       rst_n,                // Reset.
  input wire logic       async_clock_select,   // Async.
  input wire logic [2:0] clock_source_field,   // Source.
  input wire logic [1:0] wgm_low_a,            // Mode low.
  input wire logic       wgm_high_b,           // Mode high.
  input wire logic       count_wr,             // Write.
  input wire logic [7:0] count_wdata,          // Data.
  input wire logic [7:0] count_value,          // Count.
  input wire logic [1:0] force_compare_strobe, // Force.
  input wire logic [1:0] output_action_a,      // Action.
  input wire logic [2:0] irq_enable,           // Enables.
  input wire logic [2:0] flag_clear_wr,        // Clears.
  input wire logic       overflow_flag,        // Overflow.
  input wire logic       match_flag_a,         // Flag A.
  input wire logic       match_flag_b,         // Flag B.
  input wire logic [2:0] irq_request,          // Requests.
  input wire logic [1:0] port_data,            // Port.
  input wire logic [1:0] port_dir,             // Direction.
  input wire logic [1:0] wave_output,          // Pins.
  input wire logic [1:0] wave_output_oe        // Enables.
);
  logic [2:0] stop_cnt;
  logic [2:0] run_cnt;
  wire        normal_mode = ({wgm_high_b, wgm_low_a} == 3'h0);
  wire        stop_now = (clock_source_field == 3'h0) && !async_clock_select;
  wire        run_now = (clock_source_field == 3'h1) && !async_clock_select && normal_mode && !count_wr;
  // The tick is registered, so the stopped, count-up, clear and force checks wait until a counter reaches 4 before they apply.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stop_cnt <= 3'h0;
      run_cnt <= 3'h0;
    end else begin
      stop_cnt <= !stop_now ? 3'h0 : (stop_cnt == 3'h7 ? stop_cnt : stop_cnt + 3'h1);
      run_cnt <= !run_now ? 3'h0 : (run_cnt == 3'h7 ? run_cnt : run_cnt + 3'h1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_stopped;
    stop_cnt >= 3'h4 && !count_wr |=> $stable(count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");
  property p_write_wins;
    count_wr |=> count_value == $past(count_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");
  property p_count_up;
    run_cnt >= 3'h4 |-> count_value == $past(count_value) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("normal count not plus one");
  property p_overflow;
    normal_mode && $past(count_value) == 8'hFF && count_value == 8'h00 && !$past(count_wr) |-> ##[0:2] overflow_flag;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag missing");
  property p_irq;
    $past(rst_n) |-> irq_request == $past({match_flag_b, match_flag_a, overflow_flag} & irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
  property p_clear;
    stop_cnt >= 3'h4 && flag_clear_wr[1] |=> !match_flag_a;
  endproperty
  a_clear: assert property (p_clear) else $error("flag A not cleared");
  property p_force_no_flag;
    stop_cnt >= 3'h4 && force_compare_strobe[0] && !match_flag_a |=> !match_flag_a;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag A");
  property p_port_pass;
    $past(rst_n) && $past(output_action_a) == 2'h0 |-> wave_output[0] == $past(port_data[0]);
  endproperty
  a_port_pass: assert property (p_port_pass) else $error("port value not passed");
  property p_dir;
    $past(rst_n) |-> wave_output_oe == $past(port_dir);
  endproperty
  a_dir: assert property (p_dir) else $error("pin enable not from direction");
  c_ovf: cover property ($rose(overflow_flag));
  c_flag_b: cover property ($rose(match_flag_b));
  c_force: cover property (stop_cnt >= 3'h4 && force_compare_strobe[0]);
endmodule // tcu8_timer_asserts
bind tcu8_timer tcu8_timer_asserts u_chk (.core_clk, .rst_n, .async_clock_select, .clock_source_field,
  .wgm_low_a, .wgm_high_b, .count_wr, .count_wdata, .count_value, .force_compare_strobe, .output_action_a,
  .irq_enable, .flag_clear_wr, .overflow_flag, .match_flag_a, .match_flag_b, .irq_request, .port_data,
  .port_dir, .wave_output, .wave_output_oe);
`default_nettype wire

// file: verification/tcu8_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcu8_timer_test;
  logic        core_clk, rst_n, async_clock_select, crystal_osc_pin_in, crystal_osc_pin_out, osc_go;
  logic        wgm_high_b, count_wr, cmp_a_wr, cmp_b_wr, overflow_flag, match_flag_a, match_flag_b;
  logic [2:0]  clock_source_field, irq_enable, flag_clear_wr, irq_serviced, irq_request;
  logic [1:0]  wgm_low_a, force_compare_strobe, output_action_a, output_action_b;
  logic [1:0]  port_data, port_dir, wave_output, wave_output_oe;
  logic [7:0]  count_wdata, count_value, cmp_a_wdata, cmp_b_wdata, compare_value_a, compare_value_b, v, osc_n;
  logic [11:0] exp_q[$];
  logic [11:0] e;
  logic [1:0]  acts [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  event        chk_ev;
  integer      err_count, n_compared, seed, i, k;

  tcu8_timer uut (.core_clk, .rst_n, .async_clock_select, .crystal_osc_pin_in, .crystal_osc_pin_out,
    .clock_source_field, .wgm_low_a, .wgm_high_b, .count_wr, .count_wdata, .count_value, .cmp_a_wr,
    .cmp_a_wdata, .compare_value_a, .cmp_b_wr, .cmp_b_wdata, .compare_value_b, .force_compare_strobe,
    .output_action_a, .output_action_b, .irq_enable, .flag_clear_wr, .irq_serviced, .overflow_flag,
    .match_flag_a, .match_flag_b, .irq_request, .port_data, .port_dir, .wave_output, .wave_output_oe);
  tcu8_osc_model u_osc (.burst_len(osc_n), .burst_go(osc_go), .osc_pin(crystal_osc_pin_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic note(input logic [3:0] sel, input logic [7:0] val);
    exp_q.push_back({sel, val});
    -> chk_ev;
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_cnt(input logic [7:0] d);
    count_wdata = d;
    count_wr = 1'b1;
    cyc(1);
    count_wr = 1'b0;
  endtask
  task automatic wr_cmp(input logic [7:0] a, input logic [7:0] b);
    {cmp_a_wdata, cmp_b_wdata, cmp_a_wr, cmp_b_wr} = {a, b, 2'b11};
    cyc(1);
    {cmp_a_wr, cmp_b_wr} = 2'b00;
  endtask
  task automatic strobe(input logic [1:0] f, input logic [2:0] c, input logic [2:0] s);
    {force_compare_strobe, flag_clear_wr, irq_serviced} = {f, c, s};
    cyc(1);
    {force_compare_strobe, flag_clear_wr, irq_serviced} = 8'h00;
  endtask
  task automatic run(input integer n);
    clock_source_field = 3'h1;
    cyc(n);
    clock_source_field = 3'h0;
    cyc(4);
  endtask
  task automatic set_act(input logic [1:0] a);
    {output_action_a, output_action_b} = {a, a};
  endtask

  // Monitor: each note is checked against the outputs as soon as it is queued.
  initial begin
    forever begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        case (e[11:8])
          4'h0: check(count_value, e[7:0]);
          4'h1: check(compare_value_a, e[7:0]);
          4'h2: check(compare_value_b, e[7:0]);
          4'h3: check({5'h00, match_flag_b, match_flag_a, overflow_flag}, e[7:0]);
          4'h4: check({5'h00, irq_request}, e[7:0]);
          4'h5: check({6'h00, wave_output}, e[7:0]);
          4'h7: check({7'h00, crystal_osc_pin_out}, e[7:0]);
          default: check({6'h00, wave_output_oe}, e[7:0]);
        endcase
      end
    end
  end
  initial begin
    #2000000;
    err_count++;
    $display("ERROR %0t: run limit reached", $time);
    end_sim;
  end
  initial begin
    {err_count, n_compared, k, osc_go, osc_n} = '0;
    seed = 20;
    {rst_n, async_clock_select, clock_source_field, wgm_low_a, wgm_high_b, count_wr, count_wdata} = '0;
    {cmp_a_wr, cmp_a_wdata, cmp_b_wr, cmp_b_wdata, force_compare_strobe, output_action_a} = '0;
    {output_action_b, irq_enable, flag_clear_wr, irq_serviced, port_data, port_dir} = '0;
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    note(4'h0, 8'h00);
    note(4'h3, 8'h00);
    note(4'h6, 8'h00);
    note(4'h7, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr_cnt(v);
      cyc(2);
      note(4'h0, v);
    end
    clock_source_field = 3'h1;
    cyc(3);
    wr_cnt(8'h40);
    note(4'h0, 8'h40);
    cyc(2);
    note(4'h0, 8'h42);
    irq_enable = 3'h7;
    // Random counts above may already have wrapped; start the overflow test from clean flags.
    strobe(2'h0, 3'h7, 3'h0);
    wr_cnt(8'hFE);
    while (overflow_flag !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    if (k == 50) begin
      err_count++;
      $display("ERROR %0t: no overflow", $time);
      end_sim;
    end
    clock_source_field = 3'h0;
    cyc(4);
    note(4'h3, 8'h07);
    note(4'h4, 8'h07);
    strobe(2'h0, 3'h5, 3'h2);
    cyc(2);
    note(4'h3, 8'h00);
    note(4'h4, 8'h00);
    $display("Test count and overflow done");
    wr_cmp(8'h50, 8'h52);
    cyc(1);
    note(4'h1, 8'h50);
    note(4'h2, 8'h52);
    wr_cnt(8'h50);
    run(8);
    note(4'h3, 8'h04);
    strobe(2'h0, 3'h6, 3'h0);
    $display("Test match blocking done");
    for (i = 0; i < 4; i++) begin
      set_act(acts[i]);
      strobe(2'h3, 3'h0, 3'h0);
      cyc(2);
      note(4'h5, {6'h00, {2{~i[0]}}});
    end
    note(4'h3, 8'h00);
    set_act(2'h0);
    v = $random(seed);
    port_data = v[1:0];
    strobe(2'h3, 3'h0, 3'h0);
    cyc(2);
    note(4'h5, {6'h00, v[1:0]});
    set_act(2'h1);
    cyc(2);
    note(4'h5, 8'h00);
    {wgm_high_b, wgm_low_a} = 3'h3;
    strobe(2'h3, 3'h0, 3'h0);
    cyc(2);
    note(4'h5, 8'h00);
    port_dir = 2'h3;
    cyc(2);
    note(4'h6, 8'h03);
    wr_cmp(8'h80, 8'h90);
    cyc(2);
    note(4'h1, 8'h80);
    note(4'h2, 8'h90);
    {wgm_high_b, wgm_low_a} = 3'h0;
    wr_cmp(8'h50, 8'h52);
    set_act(2'h3);
    cyc(2);
    note(4'h5, 8'h00);
    wr_cnt(8'h4C);
    run(8);
    note(4'h5, 8'h03);
    $display("Test waveform output done");
    for (i = 0; i < 6; i++) begin
      {wgm_high_b, wgm_low_a} = modes[i];
      // odd counts never equal bottom or either compare value
      v = $random(seed) | 8'h01;
      wr_cnt(v);
      note(4'h0, v);
      run(3);
    end
    {wgm_high_b, wgm_low_a} = 3'h0;
    async_clock_select = 1'b1;
    clock_source_field = 3'h1;
    wr_cnt(8'h20);
    cyc(4);
    osc_n = 8'h05;
    osc_go = 1'b1;
    cyc(80);
    osc_go = 1'b0;
    note(4'h0, 8'h25);
    note(4'h7, 8'h01);
    $display("Test modes and crystal done");
    cyc(2);
    end_sim;
  end
endmodule // tcu8_timer_test
`default_nettype wire

// file: verilog/tcu8_compare_ch.v
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_defs.vh"
module tcu8_compare_ch (
  input  wire       core_clk,             // System clock.
  input  wire       rst_n,                // Synchronous reset, active low.
  input  wire       timer_tick,           // Tick enable.
  input  wire [7:0] count_value,          // Current count.
  input  wire       pwm_mode,             // Double buffering active.
  input  wire       fast_pwm,             // Single-slope PWM.
  input  wire       update_now,           // Reload point, driven by at_top in every PWM mode.
  input  wire       at_bottom,            // Count is at bottom.
  input  wire       at_top_tick,          // Fast PWM wraps on this tick.
  input  wire       counting_up,          // Direction of phase-correct PWM.
  input  wire       block_match,          // Match blocked after count write.
  input  wire       cmp_wr,               // Compare value write strobe.
  input  wire [7:0] cmp_wdata,            // Compare write data.
  input  wire       force_compare_strobe, // Force strobe.
  input  wire [1:0] output_action_field,  // Output action.
  output wire [7:0] cmp_active,           // Active compare value.
  output wire [7:0] cmp_read,             // Value software reads.
  output wire       match_now,            // Comparator equality.
  output wire       match_tick,           // Counted match this tick.
  output reg        wave_state            // Internal waveform output state.
);
  reg [7:0] active_reg;
  reg [7:0] buffer_reg;
  reg       wave_next;
  wire      forced;

  assign cmp_active = active_reg;
  // (R12) access target
  assign cmp_read   = pwm_mode ? buffer_reg : active_reg;
  // (R8) equality compare
  assign match_now  = (count_value == active_reg);
  // (R14) write blocking
  assign match_tick = timer_tick & match_now & ~block_match;
  // (R13) force in non-PWM
  assign forced     = force_compare_strobe & ~pwm_mode;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      active_reg <= 8'h00;
      buffer_reg <= 8'h00;
    end else begin
      if (cmp_wr)
        buffer_reg <= cmp_wdata;
      // (R11) buffered update
      if (cmp_wr && !pwm_mode)
        active_reg <= cmp_wdata;
      else if (pwm_mode && timer_tick && update_now)
        active_reg <= buffer_reg;
    end
  end

  always @* begin
    wave_next = wave_state;
    // (R17) unbuffered action
    if (forced || (match_tick && !pwm_mode)) begin
      case (output_action_field)
        `TCU8_COM_TOGGLE: wave_next = ~wave_state;
        `TCU8_COM_CLEAR:  wave_next = 1'b0;
        `TCU8_COM_SET:    wave_next = 1'b1;
        default:          wave_next = wave_state;
      endcase
    end else if (pwm_mode && output_action_field[1]) begin
      // Inverting mode is the same waveform with the polarity flipped.
      if (fast_pwm) begin
        if (match_tick)
          wave_next = output_action_field[0];
        else if (timer_tick && at_top_tick)
          wave_next = ~output_action_field[0];
      end else if (match_tick) begin
        wave_next = counting_up ? output_action_field[0] : ~output_action_field[0];
      end
    end else if (pwm_mode && output_action_field == `TCU8_COM_TOGGLE && match_tick) begin
      wave_next = ~wave_state;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n)
      wave_state <= 1'b0;
    // (R19) zero action holds
    else if (output_action_field != `TCU8_COM_OFF)
      wave_state <= wave_next;
  end

  wire unused_bottom = at_bottom;
endmodule // tcu8_compare_ch
`default_nettype wire

// file: verilog/tcu8_defs.vh
// How it works
// (R1) Tick comes from io_clock unless async_clock_select picks the crystal oscillator.
// (R2) Each tick clears, increments or decrements the counter per mode.
// (R3) Clock source field zero stops the counter.
// (R4) Software reads and writes count value with or without ticks.
// (R5) A software count write beats any clear or count that cycle.
// (R6) Waveform mode field: two low bits control A, high bit control B.
// (R7) Overflow flag set per mode; it raises an interrupt request.
// (R8) Per channel comparator signals match when count equals compare value.
// (R9) Match sets channel flag on next tick; enabled flag requests interrupt.
// (R10) Flag clears on interrupt service or a written one.
// (R11) PWM modes double buffer compare value, updated at top or bottom; the code updates at top in both PWM modes.
// (R12) Software compare access goes to buffer when buffered, else active copy.
// (R13) Force strobe acts like a match in non-PWM modes, no flag, no clear.
// (R14) Count write blocks the match on the following tick, even stopped.
// (R15) Software avoids writing count equal to compare, or bottom when counting down.
// (R16) Waveform output state survives a mode change.
// (R17) Output action bits unbuffered; apply at next match or force strobe.
// (R18) Nonzero output action overrides port output; direction stays with port.
// (R19) Output action zero leaves waveform output unchanged on match.
// (R20) Software sets waveform output before making the pin an output.
// (R21) Counter gives top indication at maximum and bottom indication at zero.
// (R22) Bottom is zero, maximum 255; top is maximum or compare value A.
`ifndef TCU8_DEFS_VH
`define TCU8_DEFS_VH
`define TCU8_BOTTOM      8'h00
`define TCU8_MAX         8'hFF
`define TCU8_WGM_NORMAL  3'h0
`define TCU8_WGM_PCPWM   3'h1
`define TCU8_WGM_CTC     3'h2
`define TCU8_WGM_FPWM    3'h3
`define TCU8_WGM_PCPWM_A 3'h5
`define TCU8_WGM_FPWM_A  3'h7
`define TCU8_CS_STOP     3'h0
`define TCU8_CS_DIV1     3'h1
`define TCU8_CS_DIV8     3'h2
`define TCU8_CS_DIV32    3'h3
`define TCU8_CS_DIV64    3'h4
`define TCU8_CS_DIV128   3'h5
`define TCU8_CS_DIV256   3'h6
`define TCU8_CS_DIV1024  3'h7
`define TCU8_COM_OFF     2'h0
`define TCU8_COM_TOGGLE  2'h1
`define TCU8_COM_CLEAR   2'h2
`define TCU8_COM_SET     2'h3
`define TCU8_PRESC_W     10
`define TCU8_SYNC_W      3
`endif

// file: verilog/tcu8_tick_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_defs.vh"
module tcu8_tick_gen (
  input  wire       core_clk,            // System clock.
  input  wire       rst_n,               // Synchronous reset, active low.
  input  wire       async_clock_select,  // Selects the crystal oscillator.
  input  wire       crystal_osc_pin_in,  // Oscillator input level.
  input  wire [2:0] clock_source_field,  // Prescaler selection.
  output reg        timer_tick           // One-cycle tick enable.
);
  reg [`TCU8_PRESC_W-1:0] presc_reg;
  reg [`TCU8_SYNC_W-1:0]  osc_sync_reg;
  reg                     src_pulse;
  reg                     tap;
  wire                    osc_rise;

  // The oscillator is far slower than core_clk, so one edge becomes one pulse.
  assign osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];

  always @(posedge core_clk) begin
    if (!rst_n) begin
      presc_reg    <= {`TCU8_PRESC_W{1'b0}};
      osc_sync_reg <= {`TCU8_SYNC_W{1'b0}};
    end else begin
      presc_reg    <= presc_reg + {{(`TCU8_PRESC_W-1){1'b0}}, 1'b1};
      osc_sync_reg <= {osc_sync_reg[1:0], crystal_osc_pin_in};
    end
  end

  always @* begin
    // (R1) source select
    src_pulse = async_clock_select ? osc_rise : 1'b1;
    case (clock_source_field)
      `TCU8_CS_STOP:    tap = 1'b0;
      `TCU8_CS_DIV1:    tap = 1'b1;
      `TCU8_CS_DIV8:    tap = &presc_reg[2:0];
      `TCU8_CS_DIV32:   tap = &presc_reg[4:0];
      `TCU8_CS_DIV64:   tap = &presc_reg[5:0];
      `TCU8_CS_DIV128:  tap = &presc_reg[6:0];
      `TCU8_CS_DIV256:  tap = &presc_reg[7:0];
      `TCU8_CS_DIV1024: tap = &presc_reg[9:0];
      default:          tap = 1'b0;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      timer_tick <= 1'b0;
    end else begin
      // (R3) stopped source
      if (async_clock_select)
        timer_tick <= src_pulse & (clock_source_field != `TCU8_CS_STOP);
      else
        timer_tick <= tap;
    end
  end
endmodule // tcu8_tick_gen
`default_nettype wire

// file: verilog/tcu8_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_defs.vh"
module tcu8_timer (
  input  wire       core_clk,             // System clock, the I/O clock.
  input  wire       rst_n,                // Synchronous reset, active low.
  input  wire       async_clock_select,   // Tick from crystal oscillator.
  input  wire       crystal_osc_pin_in,   // Oscillator input pin.
  output reg        crystal_osc_pin_out,  // Oscillator drive pin.
  input  wire [2:0] clock_source_field,   // Clock source, zero stops.
  input  wire [1:0] wgm_low_a,            // Waveform mode bits 1:0, control A.
  input  wire       wgm_high_b,           // Waveform mode bit 2, control B.
  input  wire       count_wr,             // Count value write strobe.
  input  wire [7:0] count_wdata,          // Count value write data.
  output reg  [7:0] count_value,          // Count value.
  input  wire       cmp_a_wr,             // Compare A write strobe.
  input  wire [7:0] cmp_a_wdata,          // Compare A write data.
  output reg  [7:0] compare_value_a,      // Compare A as software reads it.
  input  wire       cmp_b_wr,             // Compare B write strobe.
  input  wire [7:0] cmp_b_wdata,          // Compare B write data.
  output reg  [7:0] compare_value_b,      // Compare B as software reads it.
  input  wire [1:0] force_compare_strobe, // Force strobes, bit 0 is A.
  input  wire [1:0] output_action_a,      // Output action field A.
  input  wire [1:0] output_action_b,      // Output action field B.
  input  wire [2:0] irq_enable,           // Enables: 0 overflow, 1 A, 2 B.
  input  wire [2:0] flag_clear_wr,        // Write-one-to-clear strobes.
  input  wire [2:0] irq_serviced,         // Vector executed pulses.
  output reg        overflow_flag,        // Overflow flag.
  output reg        match_flag_a,         // Match flag A.
  output reg        match_flag_b,         // Match flag B.
  output reg  [2:0] irq_request,          // Interrupt requests.
  input  wire [1:0] port_data,            // General port output values.
  input  wire [1:0] port_dir,             // Port direction bits.
  output reg  [1:0] wave_output,          // Pin output values.
  output reg  [1:0] wave_output_oe        // Pin output enables.
);
  wire [2:0] waveform_mode_field;
  wire       timer_tick;
  wire       pwm_mode;
  wire       fast_pwm;
  wire       top_is_a;
  wire [7:0] top_value;
  wire       at_top;
  wire       at_bottom;
  wire       update_now;
  wire [7:0] act_a;
  wire [7:0] act_b;
  wire [7:0] rd_a;
  wire [7:0] rd_b;
  wire       mnow_a;
  wire       mnow_b;
  wire       mt_a;
  wire       mt_b;
  wire       wave_a;
  wire       wave_b;
  wire       set_ovf;
  wire [1:0] action_nz;
  wire [1:0] wave_int;
  wire [1:0] force_a_b;
  reg  [7:0] count_next;
  reg        dir_down_reg;
  reg        dir_down_next;
  reg        block_reg;
  reg        ovf_event;

  // (R6) mode field assembly
  assign waveform_mode_field = {wgm_high_b, wgm_low_a};
  assign pwm_mode = waveform_mode_field[0];
  assign fast_pwm = waveform_mode_field[1];
  assign top_is_a = waveform_mode_field[2] | (waveform_mode_field == `TCU8_WGM_CTC);
  // (R22) top selection
  assign top_value = top_is_a ? act_a : `TCU8_MAX;
  // (R21) top and bottom
  assign at_top    = (count_value == top_value);
  assign at_bottom = (count_value == `TCU8_BOTTOM);
  assign update_now = fast_pwm ? at_top : at_top;
  assign force_a_b = force_compare_strobe;

  tcu8_tick_gen u_tick (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .async_clock_select (async_clock_select),
    .crystal_osc_pin_in (crystal_osc_pin_in),
    .clock_source_field (clock_source_field),
    .timer_tick         (timer_tick)
  );

  tcu8_compare_ch u_ch_a (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .timer_tick           (timer_tick),
    .count_value          (count_value),
    .pwm_mode             (pwm_mode),
    .fast_pwm             (fast_pwm),
    .update_now           (update_now),
    .at_bottom            (at_bottom),
    .at_top_tick          (at_top),
    .counting_up          (~dir_down_reg),
    .block_match          (block_reg),
    .cmp_wr               (cmp_a_wr),
    .cmp_wdata            (cmp_a_wdata),
    .force_compare_strobe (force_a_b[0]),
    .output_action_field  (output_action_a),
    .cmp_active           (act_a),
    .cmp_read             (rd_a),
    .match_now            (mnow_a),
    .match_tick           (mt_a),
    .wave_state           (wave_a)
  );

  tcu8_compare_ch u_ch_b (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .timer_tick           (timer_tick),
    .count_value          (count_value),
    .pwm_mode             (pwm_mode),
    .fast_pwm             (fast_pwm),
    .update_now           (update_now),
    .at_bottom            (at_bottom),
    .at_top_tick          (at_top),
    .counting_up          (~dir_down_reg),
    .block_match          (block_reg),
    .cmp_wr               (cmp_b_wr),
    .cmp_wdata            (cmp_b_wdata),
    .force_compare_strobe (force_a_b[1]),
    .output_action_field  (output_action_b),
    .cmp_active           (act_b),
    .cmp_read             (rd_b),
    .match_now            (mnow_b),
    .match_tick           (mt_b),
    .wave_state           (wave_b)
  );

  always @* begin
    count_next    = count_value;
    dir_down_next = dir_down_reg;
    ovf_event     = 1'b0;
    // (R2) per-tick counting
    if (timer_tick) begin
      case (waveform_mode_field)
        `TCU8_WGM_NORMAL: begin
          count_next = count_value + 8'h01;
          ovf_event  = (count_value == `TCU8_MAX);
        end
        `TCU8_WGM_CTC: begin
          count_next = at_top ? `TCU8_BOTTOM : count_value + 8'h01;
          ovf_event  = (count_value == `TCU8_MAX);
        end
        `TCU8_WGM_FPWM, `TCU8_WGM_FPWM_A: begin
          count_next = at_top ? `TCU8_BOTTOM : count_value + 8'h01;
          ovf_event  = at_top;
        end
        `TCU8_WGM_PCPWM, `TCU8_WGM_PCPWM_A: begin
          // Dual slope: turn at top, overflow when bottom is reached.
          if (!dir_down_reg && at_top) begin
            dir_down_next = 1'b1;
            count_next    = count_value - 8'h01;
          end else if (dir_down_reg && at_bottom) begin
            dir_down_next = 1'b0;
            count_next    = count_value + 8'h01;
            ovf_event     = 1'b1;
          end else begin
            count_next = dir_down_reg ? count_value - 8'h01 : count_value + 8'h01;
          end
        end
        default: begin
          count_next = count_value + 8'h01;
        end
      endcase
    end
    // (R5) write has priority
    if (count_wr)
      count_next = count_wdata;
  end

  assign set_ovf = ovf_event;
  assign action_nz = {|output_action_b, |output_action_a};
  assign wave_int  = {wave_b, wave_a};

  always @(posedge core_clk) begin
    if (!rst_n) begin
      count_value         <= 8'h00;
      dir_down_reg        <= 1'b0;
      block_reg           <= 1'b0;
      overflow_flag       <= 1'b0;
      match_flag_a        <= 1'b0;
      match_flag_b        <= 1'b0;
      irq_request         <= 3'h0;
      compare_value_a     <= 8'h00;
      compare_value_b     <= 8'h00;
      wave_output         <= 2'h0;
      wave_output_oe      <= 2'h0;
      crystal_osc_pin_out <= 1'b0;
    end else begin
      // (R4) software access
      count_value  <= count_next;
      dir_down_reg <= dir_down_next;
      // (R14) hold block until a tick
      if (count_wr)
        block_reg <= 1'b1;
      else if (timer_tick)
        block_reg <= 1'b0;
      // (R7) overflow flag
      if (set_ovf)
        overflow_flag <= 1'b1;
      else if (flag_clear_wr[0] || irq_serviced[0])
        overflow_flag <= 1'b0;
      // (R9) match flags; a set beats a clear
      if (mt_a)
        match_flag_a <= 1'b1;
      // (R10) flag clearing
      else if (flag_clear_wr[1] || irq_serviced[1])
        match_flag_a <= 1'b0;
      if (mt_b)
        match_flag_b <= 1'b1;
      else if (flag_clear_wr[2] || irq_serviced[2])
        match_flag_b <= 1'b0;
      irq_request <= {match_flag_b, match_flag_a, overflow_flag} & irq_enable;
      compare_value_a <= rd_a;
      compare_value_b <= rd_b;
      // (R18) port override
      wave_output    <= (wave_int & action_nz) | (port_data & ~action_nz);
      wave_output_oe <= port_dir;
      // The oscillator amplifier is analog; the pin shows the inverted input while async_clock_select is set, else low.
      crystal_osc_pin_out <= async_clock_select & ~crystal_osc_pin_in;
    end
  end

  // (R16) wave state is never reset by mode writes; it lives in the channels.
  wire unused = mnow_a ^ mnow_b ^ act_b[0];
endmodule // tcu8_timer
`default_nettype wire
